/* src/idc_core.sv */
// decode/execute core for the increment-skip, or and move op slice
//
// Contract
// - increment-skip adds one to file, result to W (d=0) or file; no flags.
// - nonzero increment result discards prefetched instruction, runs a nop cycle.
// - increment-skip takes one, two, or three cycles when skipping two words.
// - a=0 picks the fixed access bank; a=1 uses bank select register.
// - a=0, extended set on, f up to 5Fh uses indexed literal offset.
// - or-with-literal ors W with literal into W, sets N and Z only.
// - or-with-file ors W with file, routes by d, sets N and Z.
// - pointer load is two words, 12-bit literal into pointer picked by 2 bits.
// - pointer load writes high part in first cycle, low byte in second.
// - file move copies file to W (d=0) or rewrites in place; N, Z.
// - single-word file operand is an 8-bit address inside the current bank.
// - file-to-file move reads source in cycle one, writes dest in cycle two.
// - bank literal load writes bank select; its upper four bits read zero.
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module idc_core
  import idc_pkg::*;
#(
  parameter logic [7:0] ACCESS_SPLIT = IDC_ACCESS_SPLIT
)(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic [15:0] INSTR_I,
  input  wire logic        INSTR_VALID_I,
  input  wire logic        NEXT_TWO_WORD_I,
  output logic             INSTR_READY_O,
  output logic             FLUSH_O,
  output idc_dmem_s        DMEM_REQ_O,
  input  wire logic [7:0]  DMEM_RDATA_I
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // map an 8-bit operand field onto the 12-bit data space
  // banked beats indexed, indexed beats the access split;
  // the indexed sum wraps at the top of the data space
  // instead of faulting, which keeps the adder narrow
  function automatic logic [11:0] resolve(
    input logic        a,
    input logic [7:0]  f,
    input logic [7:0]  bank_select_register,
    input logic [11:0] base,
    input logic        ext
  );
    logic [11:0] addr;
    addr = {IDC_ACCESS_LO, f};
    if (a) begin
      addr = {bank_select_register[3:0], f};
    end else if (ext && (f <= IDC_INDEX_MAX)) begin
      addr = 12'(base + {4'h0, f});
    end else if (f >= ACCESS_SPLIT) begin
      addr = {IDC_ACCESS_HI, f};
    end
    return addr;
  endfunction

  // opcode field decode of the first instruction word
  // the patterns never overlap, so the order is free;
  // a word that matches none runs as a one-cycle nop
  function automatic idc_op_e decode(input logic [15:0] i);
    idc_op_e op;
    op = op_nop;
    if (i[15:10] == IDC_OPC_INCSKIP) begin
      op = increment_skip_nonzero_op;
    end else if (i[15:10] == IDC_OPC_ORFILE) begin
      op = or_file_op;
    end else if (i[15:10] == IDC_OPC_FMOVE) begin
      op = file_move_op;
    end else if (i[15:9] == IDC_OPC_WFILE) begin
      op = working_to_file_op;
    end else if (i[15:8] == IDC_OPC_ORLIT) begin
      op = or_literal_op;
    end else if (i[15:8] == IDC_OPC_BANKLD) begin
      op = bank_literal_load_op;
    end else if (i[15:8] == IDC_OPC_LITW) begin
      op = literal_to_working_op;
    end else if (i[15:6] == IDC_OPC_PTRLOAD) begin
      op = pointer_load_op;
    end else if (i[15:12] == IDC_OPC_F2F) begin
      op = file_to_file_move_op;
    end
    return op;
  endfunction

  // ops whose operand comes from data memory in the second phase
  // the working store needs no read, so its bus stays quiet
  function automatic logic reads_file(input idc_op_e op);
    return (op == increment_skip_nonzero_op) || (op == or_file_op) ||
           (op == file_move_op) || (op == file_to_file_move_op);
  endfunction

  // ****************************************************************
  // state and arithmetic
  // ****************************************************************
  // one struct holds every flop so reset and enable act alike
  idc_state_s s;
  idc_state_s next_s;
  logic [7:0] alu_res;
  logic       alu_n;
  logic       alu_z;
  logic       to_file;
  logic       bus_req;

  // the operand is only valid during the process phase
  idc_alu u_alu (
    .w_i    (s.w),
    .file_i (DMEM_RDATA_I),
    .lit_i  (s.instr[7:0]),
    .op_i   (s.op),
    .res_o  (alu_res),
    .neg_o  (alu_n),
    .zero_o (alu_z)
  );

  // destination bit of the word being executed
  assign to_file = s.instr[IDC_D_BIT];
  assign bus_req = CYC_I && STB_I;

  // ****************************************************************
  // next state
  // ****************************************************************
  // each instruction cycle is four clocks: decode, read, process, write
  always_comb begin
    next_s       = s;
    next_s.flush = 1'b0;
    next_s.ack   = 1'b0;

    // bus slave: answer one clock after the request, drop ack next clock
    // ack always falls for a clock after a transfer; a master that
    // keeps its strobe up past that clock starts a new access
    if (bus_req && !s.ack) begin
      next_s.ack = 1'b1;
      case (ADR_I)
        IDC_REG_CTRL: next_s.dat = 32'(s.ext_en);
        IDC_REG_WORK: next_s.dat = 32'(s.w);
        IDC_REG_BANK: next_s.dat = 32'(s.bank_select_register);
        IDC_REG_STAT: next_s.dat = 32'({s.flag_n, s.flag_z});
        IDC_REG_PTR0: next_s.dat = 32'(s.file_select_pointer[0]);
        IDC_REG_PTR1: next_s.dat = 32'(s.file_select_pointer[1]);
        IDC_REG_PTR2: next_s.dat = 32'(s.file_select_pointer[2]);
        default:      next_s.dat = 32'h0000_0000;
      endcase
    end
    // a write lands on the edge where the master sees ack
    // only the control bit is writable; the rest is status
    if (bus_req && WE_I && s.ack && SEL_I[0] &&
        (ADR_I == IDC_REG_CTRL)) begin
      next_s.ext_en = DAT_I[IDC_CTRL_EXT_BIT];
    end

    case (s.state)
      ST_IDLE: begin
        if (INSTR_VALID_I) begin
          // decode at the take edge so the read starts next clock
          next_s.instr   = INSTR_I;
          next_s.op      = decode(INSTR_I);
          next_s.state   = ST_EXEC;
          next_s.q       = 2'h1;
          next_s.dmem.rd = reads_file(decode(INSTR_I));
          next_s.dmem.addr = resolve(INSTR_I[IDC_A_BIT], INSTR_I[7:0],
                                     s.bank_select_register, s.file_select_pointer[2], s.ext_en);
          if (decode(INSTR_I) == file_to_file_move_op) begin
            next_s.dmem.addr = INSTR_I[11:0];
          end
        end
      end

      ST_EXEC: begin
        next_s.q = 2'(s.q + 2'h1);
        case (s.q)
          // the read strobe lasts exactly one clock
          2'h1: next_s.dmem.rd = 1'b0;
          2'h2: begin
            // memory data is only valid now; stale in other phases
            next_s.res   = alu_res;
            next_s.res_n = alu_n;
            next_s.res_z = alu_z;
            case (s.op)
              increment_skip_nonzero_op, or_file_op, file_move_op: begin
                next_s.dmem.wr    = to_file;
                next_s.dmem.wdata = alu_res;
              end
              working_to_file_op: begin
                next_s.dmem.wr    = 1'b1;
                next_s.dmem.wdata = s.w;
              end
              file_to_file_move_op: next_s.hold = DMEM_RDATA_I;
              default: next_s.hold = s.hold;
            endcase
          end
          2'h3: begin
            // visible state moves only at the end of the write
            // phase; only a pointer load is seen half done, high part before low byte
            next_s.dmem.wr = 1'b0;
            next_s.q       = IDC_Q_FIRST;
            next_s.state   = ST_IDLE;
            case (s.op)
              increment_skip_nonzero_op, or_file_op, file_move_op: begin
                if (!to_file) begin
                  next_s.w = s.res;
                end
              end
              or_literal_op: next_s.w = s.res;
              literal_to_working_op: next_s.w = s.instr[7:0];
              bank_literal_load_op: next_s.bank_select_register = {IDC_BANK_HI_ZERO,
                                                  s.instr[3:0]};
              pointer_load_op: begin
                // select value three names no pointer and is dropped
                // high part first
                if (s.instr[5:4] != 2'h3) begin
                  next_s.file_select_pointer[s.instr[5:4]][11:8] = s.instr[3:0];
                end
              end
              default: next_s.w = s.w;
            endcase
            if ((s.op == or_literal_op) || (s.op == or_file_op) ||
                (s.op == file_move_op)) begin
              next_s.flag_n = s.res_n;
              next_s.flag_z = s.res_z;
            end
            if ((s.op == pointer_load_op) ||
                (s.op == file_to_file_move_op)) begin
              next_s.state = ST_WORD2;
            end
            if ((s.op == increment_skip_nonzero_op) && !s.res_z) begin
              next_s.state    = ST_SKIP;
              next_s.flush    = 1'b1;
              next_s.skip_cnt = NEXT_TWO_WORD_I ? 2'h2 : 2'h1;
            end
          end
          default: next_s.q = IDC_Q_FIRST;
        endcase
      end

      ST_WORD2: begin
        // stalls until fetch delivers the second word
        // fetch may take any number of clocks; nothing else is
        // accepted meanwhile
        if (INSTR_VALID_I) begin
          next_s.word2 = INSTR_I[11:0];
          next_s.state = ST_SECOND;
          next_s.q     = 2'h1;
          if (s.op == file_to_file_move_op) begin
            next_s.dmem.addr = INSTR_I[11:0];
          end
        end
      end

      ST_SECOND: begin
        // no dummy read here, at most one write
        next_s.q = 2'(s.q + 2'h1);
        if (s.q == 2'h2) begin
          if (s.op == file_to_file_move_op) begin
            next_s.dmem.wr    = 1'b1;
            next_s.dmem.wdata = s.hold;
          end
        end else if (s.q == IDC_Q_LAST) begin
          next_s.dmem.wr = 1'b0;
          next_s.q       = IDC_Q_FIRST;
          next_s.state   = ST_IDLE;
          if ((s.op == pointer_load_op) && (s.instr[5:4] != 2'h3)) begin
            next_s.file_select_pointer[s.instr[5:4]][7:0] = s.word2[7:0];
          end
        end
      end

      ST_SKIP: begin
        // skip_cnt counts instruction cycles, not clocks; fetch
        // holds the next word back until ready rises again
        // whole nop cycles
        next_s.q = 2'(s.q + 2'h1);
        if (s.q == IDC_Q_LAST) begin
          next_s.skip_cnt = 2'(s.skip_cnt - 2'h1);
          if (s.skip_cnt == 2'h1) begin
            next_s.state = ST_IDLE;
          end
        end
      end

      default: begin
        // an illegal state code falls back to idle
        next_s.state = ST_IDLE;
        next_s.q     = IDC_Q_FIRST;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // clock enable freezes everything, the bus slave included
  // reset is not gated by the enable, so a frozen core resets
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      s <= IDC_STATE_RST;
    end else if (CE_I) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // ready is combinational so an instruction is taken the same clock
  // ready drops with the enable, so fetch never hands a word
  // to a frozen core and loses it
  assign INSTR_READY_O = CE_I && ((s.state == ST_IDLE) ||
                                  (s.state == ST_WORD2));
  assign FLUSH_O       = s.flush;
  assign DMEM_REQ_O    = s.dmem;
  assign DAT_O         = s.dat;
  assign ACK_O         = s.ack;

endmodule

/* src/idc_pkg.sv */
// shared constants, types and state layout of the op decode/execute slice
package idc_pkg;

  // ****************************************************************
  // widths and phases
  // ****************************************************************
  localparam int unsigned IDC_DATA_W   = 8;
  localparam int unsigned IDC_ADDR_W   = 12;
  localparam int unsigned IDC_INSTR_W  = 16;
  localparam int unsigned IDC_ADR_W    = 8;
  localparam int unsigned IDC_FSR_N    = 3;
  localparam logic [1:0]  IDC_Q_FIRST  = 2'h0;
  localparam logic [1:0]  IDC_Q_LAST   = 2'h3;

  // ****************************************************************
  // register map (byte offsets) and fields
  // ****************************************************************
  localparam logic [7:0] IDC_REG_CTRL   = 8'h00;
  localparam logic [7:0] IDC_REG_WORK   = 8'h04;
  localparam logic [7:0] IDC_REG_BANK   = 8'h08;
  localparam logic [7:0] IDC_REG_STAT   = 8'h0C;
  localparam logic [7:0] IDC_REG_PTR0   = 8'h10;
  localparam logic [7:0] IDC_REG_PTR1   = 8'h14;
  localparam logic [7:0] IDC_REG_PTR2   = 8'h18;
  localparam int unsigned IDC_CTRL_EXT_BIT = 0;
  localparam int unsigned IDC_STAT_Z_BIT   = 0;
  localparam int unsigned IDC_STAT_N_BIT   = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  IDC_W_RST    = 8'h00;
  localparam logic [7:0]  IDC_BSR_RST  = 8'h00;
  localparam logic [11:0] IDC_FSR_RST  = 12'h000;
  localparam logic        IDC_CTRL_RST = 1'b0;
  localparam logic        IDC_FLAG_RST = 1'b0;

  // ****************************************************************
  // instruction encodings
  // ****************************************************************
  localparam int unsigned IDC_D_BIT = 9;
  localparam int unsigned IDC_A_BIT = 8;
  localparam logic [5:0] IDC_OPC_INCSKIP = 6'h12;
  localparam logic [5:0] IDC_OPC_ORFILE  = 6'h04;
  localparam logic [5:0] IDC_OPC_FMOVE   = 6'h14;
  localparam logic [6:0] IDC_OPC_WFILE   = 7'h37;
  localparam logic [7:0] IDC_OPC_ORLIT   = 8'h09;
  localparam logic [7:0] IDC_OPC_BANKLD  = 8'h01;
  localparam logic [7:0] IDC_OPC_LITW    = 8'h0E;
  localparam logic [9:0] IDC_OPC_PTRLOAD = 10'h3B8;
  localparam logic [3:0] IDC_OPC_F2F     = 4'hC;

  // ****************************************************************
  // addressing
  // ****************************************************************
  localparam logic [7:0] IDC_INDEX_MAX     = 8'h5F;
  localparam logic [7:0] IDC_ACCESS_SPLIT  = 8'h80;
  localparam logic [3:0] IDC_ACCESS_LO     = 4'h0;
  localparam logic [3:0] IDC_ACCESS_HI     = 4'hF;
  localparam logic [3:0] IDC_BANK_HI_ZERO  = 4'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    op_nop,
    increment_skip_nonzero_op,
    or_literal_op,
    or_file_op,
    pointer_load_op,
    file_move_op,
    file_to_file_move_op,
    bank_literal_load_op,
    literal_to_working_op,
    working_to_file_op
  } idc_op_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_WORD2,
    ST_SECOND,
    ST_SKIP
  } idc_fsm_e;

  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } idc_dmem_s;

  typedef struct packed {
    idc_fsm_e         state;
    logic [1:0]       q;
    idc_op_e          op;
    logic [15:0]      instr;
    logic [11:0]      word2;
    logic [7:0]       hold;
    logic [7:0]       res;
    logic             res_n;
    logic             res_z;
    logic [1:0]       skip_cnt;
    logic [7:0]       w;
    logic [7:0]       bank_select_register;
    logic [2:0][11:0] file_select_pointer;
    logic             flag_n;
    logic             flag_z;
    logic             ext_en;
    idc_dmem_s        dmem;
    logic             flush;
    logic             ack;
    logic [31:0]      dat;
  } idc_state_s;

  localparam idc_state_s IDC_STATE_RST = '{
    state:    ST_IDLE,
    q:        IDC_Q_FIRST,
    op:       op_nop,
    instr:    16'h0000,
    word2:    12'h000,
    hold:     8'h00,
    res:      8'h00,
    res_n:    1'b0,
    res_z:    1'b0,
    skip_cnt: 2'h0,
    w:        IDC_W_RST,
    bank_select_register:      IDC_BSR_RST,
    file_select_pointer:      {IDC_FSR_RST, IDC_FSR_RST, IDC_FSR_RST},
    flag_n:   IDC_FLAG_RST,
    flag_z:   IDC_FLAG_RST,
    ext_en:   IDC_CTRL_RST,
    dmem:     '{addr: 12'h000, rd: 1'b0, wr: 1'b0, wdata: 8'h00},
    flush:    1'b0,
    ack:      1'b0,
    dat:      32'h0000_0000
  };

endpackage

/* src/idc_alu.sv */
// result and flag arithmetic for the byte operations
`timescale 1ns/1ps
module idc_alu
  import idc_pkg::*;
(
  input  wire logic [7:0] w_i,
  input  wire logic [7:0] file_i,
  input  wire logic [7:0] lit_i,
  input  idc_op_e         op_i,
  output logic      [7:0] res_o,
  output logic            neg_o,
  output logic            zero_o
);

  // ****************************************************************
  // datapath
  // ****************************************************************
  // one shared adder/or path; unused ops just pass the literal
  always_comb begin
    case (op_i)
      increment_skip_nonzero_op: res_o = 8'(file_i + 8'h01);
      or_literal_op:             res_o = w_i | lit_i;
      or_file_op:                res_o = w_i | file_i;
      file_move_op:              res_o = file_i;
      default:                   res_o = lit_i;
    endcase
  end

  // flags are computed always; the core decides whether to keep them
  assign neg_o  = res_o[7];
  assign zero_o = (res_o == 8'h00);

endmodule

/* bench/idc_dmem_model.sv */
// data memory and register file model on the far side of the slice
`timescale 1ns/1ps
module idc_dmem_model
  import idc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire idc_dmem_s req_i,
  output logic     [7:0] rdata_o
);
  logic [7:0] mem [0:4095];

  initial rdata_o = 8'h00;

  // read data lands the clock after rd; when idle the bus shows the
  // inverse of its last value so a late sample never sees stale data
  always @(posedge clk_i) begin
    if (req_i.wr)
      mem[req_i.addr] <= req_i.wdata;
    rdata_o <= req_i.rd ? mem[req_i.addr] : ~rdata_o;
  end
endmodule

/* bench/idc_core_asserts.sv */
// concurrent checks on the ports of the op decode/execute slice
`timescale 1ns/1ps
module idc_core_asserts
  import idc_pkg::*;
#(
  parameter logic [7:0] ACCESS_SPLIT = IDC_ACCESS_SPLIT
)(
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        CE_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic [15:0] INSTR_I,
  input wire logic        INSTR_VALID_I,
  input wire logic        NEXT_TWO_WORD_I,
  input wire logic        INSTR_READY_O,
  input wire logic        FLUSH_O,
  input wire idc_dmem_s   DMEM_REQ_O,
  input wire logic [7:0]  DMEM_RDATA_I
);
  logic take, inc, f2f, lit, wfl, fop, f2f_w2;

  // decode of the word being taken this cycle
  assign take = INSTR_VALID_I && INSTR_READY_O;
  assign inc  = INSTR_I[15:10] == IDC_OPC_INCSKIP;
  assign f2f  = INSTR_I[15:12] == IDC_OPC_F2F;
  assign wfl  = INSTR_I[15:9] == IDC_OPC_WFILE;
  assign lit  = INSTR_I[15:8] == IDC_OPC_LITW
             || INSTR_I[15:8] == IDC_OPC_ORLIT
             || INSTR_I[15:8] == IDC_OPC_BANKLD;
  assign fop  = inc || wfl || INSTR_I[15:10] == IDC_OPC_FMOVE
             || INSTR_I[15:10] == IDC_OPC_ORFILE;

  // marks that the next word taken is the destination word
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I)
      f2f_w2 <= 1'b0;
    else if (take)
      f2f_w2 <= f2f && !f2f_w2;
  end

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  a_inc_wdata: assert property (
    take && inc && INSTR_I[IDC_D_BIT] |=> ##2 DMEM_REQ_O.wr
    && DMEM_REQ_O.wdata == $past(DMEM_RDATA_I) + 8'h01)
    else $error("increment write data wrong");
  a_skip_flush: assert property (
    take && inc ##2 1'b1 |->
    ##2 (FLUSH_O == ($past(DMEM_RDATA_I, 2) != 8'hFF)))
    else $error("skip flush wrong");
  a_skip_ready: assert property (
    $rose(FLUSH_O) |-> !INSTR_READY_O [*4]
    ##1 (INSTR_READY_O == !$past(NEXT_TWO_WORD_I, 5)))
    else $error("skip length wrong");
  a_access_hi: assert property (
    take && fop && !INSTR_I[IDC_A_BIT] && INSTR_I[7] |=> ##2
    DMEM_REQ_O.addr == {IDC_ACCESS_HI, $past(INSTR_I[7:0], 3)})
    else $error("access bank address wrong");
  a_f2f_src: assert property (
    take && f2f && !f2f_w2 |=> DMEM_REQ_O.rd
    && DMEM_REQ_O.addr == $past(INSTR_I[11:0]))
    else $error("source read wrong");
  a_f2f_dst: assert property (
    take && f2f_w2 |=> !DMEM_REQ_O.rd [*2] ##1 (DMEM_REQ_O.wr
    && !DMEM_REQ_O.rd && DMEM_REQ_O.addr == $past(INSTR_I[11:0], 3)))
    else $error("destination write wrong");
  a_lit_no_mem: assert property (
    take && lit |=> (!DMEM_REQ_O.rd && !DMEM_REQ_O.wr) [*3])
    else $error("literal op touched memory");
  a_wfile_write: assert property (
    take && wfl |=> !DMEM_REQ_O.rd [*2] ##1
    (DMEM_REQ_O.wr && !DMEM_REQ_O.rd))
    else $error("working store wrong");

  c_skip: cover property ($rose(FLUSH_O));
  c_f2f: cover property (take && f2f_w2);
  c_inc: cover property (take && inc);
endmodule

bind idc_core idc_core_asserts #(.ACCESS_SPLIT(ACCESS_SPLIT)) u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
  .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .INSTR_I(INSTR_I),
  .INSTR_VALID_I(INSTR_VALID_I), .NEXT_TWO_WORD_I(NEXT_TWO_WORD_I),
  .INSTR_READY_O(INSTR_READY_O), .FLUSH_O(FLUSH_O),
  .DMEM_REQ_O(DMEM_REQ_O), .DMEM_RDATA_I(DMEM_RDATA_I));

/* bench/test_incskip_or_move_op_decode.sv */
// self-checking bench for the op decode/execute slice
`timescale 1ns/1ps
module test_incskip_or_move_op_decode;
  import idc_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, rdy, flush, ivld, two, fl, ce;
  logic [3:0]  sel;
  logic [7:0]  adr, rdata, w, b, v, f;
  logic [11:0] k, p;
  logic [15:0] ins;
  logic [31:0] dat, dat_o, rv, st;
  logic [31:0] s = 32'h3CDA;
  idc_dmem_s   req;
  int          n_errors = 0;
  int          compares = 0;
  int          n;

  idc_core dut_u (
    .REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o),
    .ACK_O(ack), .INSTR_I(ins), .INSTR_VALID_I(ivld),
    .NEXT_TWO_WORD_I(two), .INSTR_READY_O(rdy), .FLUSH_O(flush),
    .DMEM_REQ_O(req), .DMEM_RDATA_I(rdata));
  idc_dmem_model mem_u (.clk_i(clk), .req_i(req), .rdata_o(rdata));

  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // status as read back: bit1 negative, bit0 zero
  function automatic logic [31:0] nzf(input logic [7:0] x);
    return {30'h0, x[7], x == 8'h00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic wr, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] sl);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    sel <= sl;
    // ack is looked at between edges, where it has settled
    @(negedge clk);
    while (ack !== 1'b1) @(negedge clk);
    @(posedge clk);
    rv = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk($sformatf("reg %h", a), rv, e);
  endtask

  // hand one word over, then count cycles until the next is accepted
  task automatic ex(input logic [15:0] i);
    ins <= i;
    ivld <= 1'b1;
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    ins <= ~i;
    ivld <= 1'b0;
    n = 0;
    fl = 1'b0;
    do begin
      @(negedge clk);
      n++;
      fl |= (flush === 1'b1);
    end while (rdy !== 1'b1);
    @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cuts a hang short well beyond the expected run length
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    $display("timeout");
    report_and_stop();
  end

  // ****
  // scenarios
  // ****
  initial begin
    {cyc, stb, we, ivld, two} = '0;
    ce = 1'b1;
    {adr, sel, dat, ins} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 32; a += 4)
      rchk(8'(a), 32'h0);
    wb(1'b1, IDC_REG_WORK, 32'hFFFF_FFFF, 4'hF);
    wb(1'b1, IDC_REG_CTRL, 32'h1, 4'hE);
    rchk(IDC_REG_WORK, 32'h0);
    rchk(IDC_REG_CTRL, 32'h0);
    $display("test regs done");
    st = 32'h0;
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 8'h00 : 8'(xs());
      ex({IDC_OPC_LITW, w});
      rchk(IDC_REG_WORK, {24'h0, w});
      rchk(IDC_REG_STAT, st);
      v = (i == 0) ? 8'h00 : 8'(xs());
      ex({IDC_OPC_ORLIT, v});
      w |= v;
      st = nzf(w);
      rchk(IDC_REG_WORK, {24'h0, w});
      rchk(IDC_REG_STAT, st);
    end
    b = 8'(xs()) | 8'hF0;
    ex({IDC_OPC_BANKLD, b});
    b = {4'h0, b[3:0]};
    rchk(IDC_REG_BANK, {24'h0, b});
    // four frozen clocks mid-op stretch the literal load by four
    fork
      ex({IDC_OPC_LITW, 8'hA5});
      begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk("frozen cycles", n, 8);
    rchk(IDC_REG_WORK, 32'h0000_00A5);
    $display("test literal done");
    for (int i = 0; i < 3; i++) begin
      f = 8'(xs());
      v = (i == 0) ? 8'h00 : 8'(xs());
      mem_u.mem[{b[3:0], f}] = v;
      ex({IDC_OPC_FMOVE, 1'b0, 1'b1, f});
      w = v;
      st = nzf(w);
      rchk(IDC_REG_WORK, {24'h0, w});
      rchk(IDC_REG_STAT, st);
    end
    f = 8'(xs());
    v = 8'(xs());
    mem_u.mem[{b[3:0], f}] = v;
    ex({IDC_OPC_ORFILE, 1'b1, 1'b1, f});
    chk("or file", mem_u.mem[{b[3:0], f}], w | v);
    rchk(IDC_REG_WORK, {24'h0, w});
    st = nzf(w | v);
    rchk(IDC_REG_STAT, st);
    f = 8'(xs()) | 8'h80;
    ex({IDC_OPC_WFILE, 1'b0, f});
    chk("store", mem_u.mem[{4'hF, f}], w);
    rchk(IDC_REG_STAT, st);
    $display("test file done");
    for (int i = 0; i < 3; i++) begin
      f = 8'(xs());
      v = (i == 0) ? 8'hFF : 8'(xs()) & 8'h7F;
      mem_u.mem[{b[3:0], f}] = v;
      two <= (i == 2);
      ex({IDC_OPC_INCSKIP, i != 1, 1'b1, f});
      two <= 1'b0;
      chk("cycles", n, 4 * (i + 1));
      chk("flush", fl, i != 0);
      if (i == 1) begin
        w = 8'(v + 8'h01);
        rchk(IDC_REG_WORK, {24'h0, w});
      end else
        chk("inc", mem_u.mem[{b[3:0], f}], 8'(v + 8'h01));
      rchk(IDC_REG_STAT, st);
    end
    $display("test skip done");
    for (int i = 0; i < 3; i++) begin
      k = 12'(xs());
      ex({IDC_OPC_PTRLOAD, 2'(i), k[11:8]});
      rchk(IDC_REG_PTR0 + 8'(4 * i), {20'h0, k[11:8], 8'h00});
      ex({8'hF0, k[7:0]});
      rchk(IDC_REG_PTR0 + 8'(4 * i), {20'h0, k});
    end
    p = k;
    k = 12'(xs());
    v = 8'(xs());
    mem_u.mem[k] = v;
    ex({IDC_OPC_F2F, k});
    ex({4'hF, k ^ 12'h800});
    chk("move", mem_u.mem[k ^ 12'h800], v);
    $display("test pointer done");
    wb(1'b1, IDC_REG_CTRL, 32'h1, 4'h1);
    for (int i = 0; i < 2; i++) begin
      f = 8'h5F + 8'(i);
      v = 8'(xs());
      mem_u.mem[i ? {4'h0, f} : 12'(p + 12'(f))] = v;
      ex({IDC_OPC_FMOVE, 1'b0, 1'b0, f});
      rchk(IDC_REG_WORK, {24'h0, v});
    end
    $display("test indexed done");
    report_and_stop();
  end
endmodule
